// ==== src/adcsq_top.sv ====
`timescale 1ns/1ns
module adcsq_top (
	input  wire logic                 aclk,
	input  wire logic                 aresetn,
	input  wire logic                 ce,
	input  wire logic [7:0]           s_axi_awaddr,
	input  wire logic                 s_axi_awvalid,
	output logic                      s_axi_awready,
	input  wire logic [31:0]          s_axi_wdata,
	input  wire logic [3:0]           s_axi_wstrb,
	input  wire logic                 s_axi_wvalid,
	output logic                      s_axi_wready,
	output logic [1:0]                s_axi_bresp,
	output logic                      s_axi_bvalid,
	input  wire logic                 s_axi_bready,
	input  wire logic [7:0]           s_axi_araddr,
	input  wire logic                 s_axi_arvalid,
	output logic                      s_axi_arready,
	output logic [31:0]               s_axi_rdata,
	output logic [1:0]                s_axi_rresp,
	output logic                      s_axi_rvalid,
	input  wire logic                 s_axi_rready,
	input  wire logic                 ext_acq_clock_in,
	input  wire logic                 converter_busy_n,
	input  wire logic [15:0]          conv_code,
	input  wire logic [3:0]           sync_digital_in_bits,
	output logic                      conv_start_n,
	output adcsq_pkg::adcsq_entry_s   mux_entry,
	output logic                      simul_hold_out,
	output logic                      fifo_push,
	output logic [15:0]               fifo_data,
	output logic                      irq
);

	typedef enum logic [1:0] {cv_idle, cv_start, cv_wait} adcsq_cv_e;

	// Bus state
	logic [7:0]  waddr_q;
	logic [31:0] wdata_q;
	logic [3:0]  wstrb_q;
	logic        aw_got_q;
	logic        w_got_q;
	logic        wr_en;
	logic [31:0] rdata_d;
	logic        rd_ok_d;
	logic        rd_take;

	// Control and configuration
	logic                         run_q;
	logic                         run_prev_q;
	logic                         ext_sel_q;
	logic                         sdi_fmt_q;
	logic                         hold_en_q;
	logic [adcsq_pkg::SI_W-1:0]   si_q;
	logic [adcsq_pkg::SI2_W-1:0]  si2_q;
	logic [adcsq_pkg::PSC_W-1:0]  psc_q;
	logic [adcsq_pkg::NCH_W-1:0]  nch_q;
	logic [adcsq_pkg::IRQ_W-1:0]  stat_q;
	logic [adcsq_pkg::IRQ_W-1:0]  mask_q;
	logic [adcsq_pkg::IRQ_W-1:0]  evt;
	logic                         sw_start;
	logic                         q_clr;

	// Clock base, pacing and sequencing
	logic [5:0]                   tb_acc_q;
	logic [6:0]                   tb_sum;
	logic                         ext_prev_q;
	logic                         acq_tick;
	logic                         scan_fire;
	logic                         samp_fire;
	logic                         run_rise;
	logic                         scan_start;
	logic                         issue;
	logic [adcsq_pkg::NCH_W-1:0]  issue_left_q;
	logic [adcsq_pkg::NCH_W-1:0]  capt_left_q;
	logic [adcsq_pkg::PSC_W-1:0]  scans_left_q;
	logic                         scan_done;
	logic                         acq_end;

	// Queue and conversion
	adcsq_pkg::adcsq_entry_s      queue_mem [adcsq_pkg::QUEUE_DEPTH];
	logic [9:0]                   qlen_q;
	logic [8:0]                   rd_ptr_q;
	logic                         req_q;
	adcsq_cv_e                    cv_q;
	logic                         busy_prev_q;
	logic                         conv_done;
	logic [15:0]                  word_d;
	logic [15:0]                  sample_q;
	logic                         avail_q;

	// Byte-lane merge of a write into a stored value
	function automatic logic [31:0] adcsq_merge(input logic [31:0] old, input logic [31:0] nv,
		input logic [3:0] strb);
		logic [31:0] res;
		res = old;
		for (int i = 0; i < 4; i++)
			if (strb[i])
				res[8*i +: 8] = nv[8*i +: 8];
		return res;
	endfunction : adcsq_merge

	function automatic logic adcsq_hit(input logic [7:0] a, input logic [7:0] ofs);
		return a[7:2] == ofs[7:2];
	endfunction : adcsq_hit

	// Write address and data taken in either order, answered after both
	assign wr_en = aw_got_q && w_got_q && !s_axi_bvalid;

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			aw_got_q      <= 1'b0;
			w_got_q       <= 1'b0;
			waddr_q       <= 8'h00;
			wdata_q       <= 32'h0000_0000;
			wstrb_q       <= 4'h0;
			s_axi_awready <= 1'b1;
			s_axi_wready  <= 1'b1;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= adcsq_pkg::RESP_OKAY;
		end
		else if (ce)
		begin
			if (s_axi_awvalid && s_axi_awready)
			begin
				waddr_q       <= s_axi_awaddr;
				aw_got_q      <= 1'b1;
				s_axi_awready <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready)
			begin
				wdata_q      <= s_axi_wdata;
				wstrb_q      <= s_axi_wstrb;
				w_got_q      <= 1'b1;
				s_axi_wready <= 1'b0;
			end
			if (wr_en)
			begin
				aw_got_q     <= 1'b0;
				w_got_q      <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= (waddr_q[7:2] > adcsq_pkg::OFS_IMASK[7:2]) ?
					adcsq_pkg::RESP_SLVERR : adcsq_pkg::RESP_OKAY;
			end
			if (s_axi_bvalid && s_axi_bready)
			begin
				s_axi_bvalid  <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready  <= 1'b1;
			end
		end
	end

	// Control pulses from the control register
	assign sw_start = wr_en && adcsq_hit(waddr_q, adcsq_pkg::OFS_CTRL) && wstrb_q[0]
		&& wdata_q[adcsq_pkg::CTRL_SWSTRT] && !run_q;
	assign q_clr    = wr_en && adcsq_hit(waddr_q, adcsq_pkg::OFS_CTRL) && wstrb_q[0]
		&& wdata_q[adcsq_pkg::CTRL_QCLR];

	// Control register; a software write beats the end-of-acquisition stop
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			run_q      <= 1'b0;
			run_prev_q <= 1'b0;
			ext_sel_q  <= 1'b0;
			sdi_fmt_q  <= 1'b0;
			hold_en_q  <= 1'b0;
		end
		else if (ce)
		begin
			run_prev_q <= run_q;
			if (acq_end)
				run_q <= 1'b0;
			if (wr_en && adcsq_hit(waddr_q, adcsq_pkg::OFS_CTRL) && wstrb_q[0])
			begin
				run_q     <= wdata_q[adcsq_pkg::CTRL_RUN];
				ext_sel_q <= wdata_q[adcsq_pkg::CTRL_EXTTB];
				sdi_fmt_q <= wdata_q[adcsq_pkg::CTRL_SDIFMT];
				hold_en_q <= wdata_q[adcsq_pkg::CTRL_HOLDEN];
			end
		end
	end

	// Pacing and count registers
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			si_q  <= adcsq_pkg::SI_RST;
			si2_q <= adcsq_pkg::SI2_RST;
			psc_q <= adcsq_pkg::PSC_RST;
			nch_q <= adcsq_pkg::NCH_RST;
		end
		else if (ce && wr_en)
		begin
			if (adcsq_hit(waddr_q, adcsq_pkg::OFS_SI))
				si_q <= 24'(adcsq_merge({8'h00, si_q}, wdata_q, wstrb_q));
			if (adcsq_hit(waddr_q, adcsq_pkg::OFS_SI2))
				si2_q <= 16'(adcsq_merge({16'h0000, si2_q}, wdata_q, wstrb_q));
			if (adcsq_hit(waddr_q, adcsq_pkg::OFS_PSC))
				psc_q <= 24'(adcsq_merge({8'h00, psc_q}, wdata_q, wstrb_q));
			if (adcsq_hit(waddr_q, adcsq_pkg::OFS_NCH))
				nch_q <= 9'(adcsq_merge({23'h00_0000, nch_q}, wdata_q, wstrb_q));
		end
	end

	// Interrupt status, mask and output; a new event beats its own clear
	assign evt = {acq_end, scan_done, conv_done};

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			stat_q <= '0;
			mask_q <= '0;
			irq    <= 1'b0;
		end
		else if (ce)
		begin
			if (wr_en && adcsq_hit(waddr_q, adcsq_pkg::OFS_ISTAT) && wstrb_q[0])
				stat_q <= (stat_q & ~wdata_q[adcsq_pkg::IRQ_W-1:0]) | evt;
			else
				stat_q <= stat_q | evt;
			if (wr_en && adcsq_hit(waddr_q, adcsq_pkg::OFS_IMASK) && wstrb_q[0])
				mask_q <= wdata_q[adcsq_pkg::IRQ_W-1:0];
			irq <= |(stat_q & mask_q);
		end
	end

	// Read data mux
	always_comb
	begin
		rdata_d = 32'h0000_0000;
		rd_ok_d = 1'b1;
		unique case (s_axi_araddr[7:2])
			adcsq_pkg::OFS_CTRL[7:2]:
				rdata_d[5:0] = {1'b0, hold_en_q, sdi_fmt_q, ext_sel_q, 1'b0, run_q};
			adcsq_pkg::OFS_STATUS[7:2]:
			begin
				rdata_d[adcsq_pkg::ST_AVAIL]     = avail_q;
				rdata_d[adcsq_pkg::ST_RUN]       = run_q;
				rdata_d[adcsq_pkg::ST_BUSY]      = cv_q != cv_idle;
				rdata_d[adcsq_pkg::ST_QLEN +: 10] = qlen_q;
			end
			adcsq_pkg::OFS_SI[7:2]:     rdata_d[23:0] = si_q;
			adcsq_pkg::OFS_SI2[7:2]:    rdata_d[15:0] = si2_q;
			adcsq_pkg::OFS_PSC[7:2]:    rdata_d[23:0] = psc_q;
			adcsq_pkg::OFS_NCH[7:2]:    rdata_d[8:0]  = nch_q;
			adcsq_pkg::OFS_QUEUE[7:2]:  rdata_d[8:0]  = rd_ptr_q;
			adcsq_pkg::OFS_SAMPLE[7:2]: rdata_d[15:0] = sample_q;
			adcsq_pkg::OFS_ISTAT[7:2]:  rdata_d[2:0]  = stat_q;
			adcsq_pkg::OFS_IMASK[7:2]:  rdata_d[2:0]  = mask_q;
			default:                    rd_ok_d       = 1'b0;
		endcase
	end

	assign rd_take = s_axi_arvalid && s_axi_arready;

	// Read channel, one cycle after the address is taken
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h0000_0000;
			s_axi_rresp   <= adcsq_pkg::RESP_OKAY;
		end
		else if (ce)
		begin
			if (rd_take)
			begin
				s_axi_arready <= 1'b0;
				s_axi_rvalid  <= 1'b1;
				s_axi_rdata   <= rdata_d;
				s_axi_rresp   <= rd_ok_d ? adcsq_pkg::RESP_OKAY : adcsq_pkg::RESP_SLVERR;
			end
			else if (s_axi_rvalid && s_axi_rready)
			begin
				s_axi_rvalid  <= 1'b0;
				s_axi_arready <= 1'b1;
			end
		end
	end

	// Internal 40 MHz base as fractional ticks of the system clock
	assign tb_sum   = {1'b0, tb_acc_q} + adcsq_pkg::TB_STEP;
	assign acq_tick = ext_sel_q ? (ext_acq_clock_in && !ext_prev_q) : (tb_sum >= adcsq_pkg::TB_MOD);

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			tb_acc_q   <= 6'h00;
			ext_prev_q <= 1'b0;
		end
		else if (ce)
		begin
			ext_prev_q <= ext_acq_clock_in;
			tb_acc_q   <= (tb_sum >= adcsq_pkg::TB_MOD) ? 6'(tb_sum - adcsq_pkg::TB_MOD) : tb_sum[5:0];
		end
	end

	// Scan interval and sample interval pacing counters
	adcsq_counter #(.W(adcsq_pkg::SI_W)) u_scan_ivl (
		.aclk    (aclk),
		.aresetn (aresetn),
		.ce      (ce),
		.load    (run_rise),
		.tick    (acq_tick && run_q),
		.period  (si_q),
		.fire    (scan_fire)
	);

	adcsq_counter #(.W(adcsq_pkg::SI2_W)) u_samp_ivl (
		.aclk    (aclk),
		.aresetn (aresetn),
		.ce      (ce),
		.load    (scan_start),
		.tick    (acq_tick && run_q && issue_left_q != '0),
		.period  (si2_q),
		.fire    (samp_fire)
	);

	// Scan starts on run and each scan tick; first conversion at once
	assign run_rise   = run_q && !run_prev_q;
	assign scan_start = run_q && (run_rise || scan_fire);
	assign issue      = scan_start ? (nch_q != '0) : samp_fire;
	assign scan_done  = conv_done && capt_left_q == 9'h001;
	assign acq_end    = scan_done && run_q && scans_left_q == 24'h00_0001;

	// Conversions issued and captured per scan, scans per acquisition
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			issue_left_q <= '0;
			capt_left_q  <= '0;
			scans_left_q <= '0;
		end
		else if (ce)
		begin
			if (scan_start)
				issue_left_q <= (nch_q != '0) ? nch_q - 9'h001 : '0;
			else if (samp_fire)
				issue_left_q <= issue_left_q - 9'h001;
			if (scan_start)
				capt_left_q <= nch_q;
			else if (conv_done && capt_left_q != '0)
				capt_left_q <= capt_left_q - 9'h001;
			if (run_rise)
				scans_left_q <= psc_q;
			else if (scan_done && scans_left_q != '0)
				scans_left_q <= scans_left_q - 24'h00_0001;
		end
	end

	// Simultaneous hold spans every conversion of a scan
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			simul_hold_out <= 1'b0;
		else if (ce)
		begin
			if (scan_start)
				simul_hold_out <= hold_en_q;
			else if (scan_done || !run_q)
				simul_hold_out <= 1'b0;
		end
	end

	// Queue storage, written in order
	always_ff @(posedge aclk)
	begin
		if (ce && wr_en && adcsq_hit(waddr_q, adcsq_pkg::OFS_QUEUE) && qlen_q < 10'h200)
			queue_mem[qlen_q[8:0]] <= wdata_q[adcsq_pkg::ENTRY_W-1:0];
	end

	// Queue length and read position, wrapping after the last entry
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			qlen_q   <= 10'h000;
			rd_ptr_q <= 9'h000;
		end
		else if (ce)
		begin
			if (q_clr)
			begin
				qlen_q   <= 10'h000;
				rd_ptr_q <= 9'h000;
			end
			else
			begin
				if (wr_en && adcsq_hit(waddr_q, adcsq_pkg::OFS_QUEUE) && qlen_q < 10'h200)
					qlen_q <= qlen_q + 10'h001;
				if (cv_q == cv_idle && req_q)
					rd_ptr_q <= ({1'b0, rd_ptr_q} + 10'h001 >= qlen_q) ? 9'h000 : rd_ptr_q + 9'h001;
			end
		end
	end

	// Pending conversion request; a new request beats the take
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			req_q <= 1'b0;
		else if (ce)
			req_q <= issue || sw_start || (req_q && cv_q != cv_idle);
	end

	// Result word: digital bits in the low nibble or plain 16-bit code
	assign word_d    = sdi_fmt_q ? {conv_code[15:4], sync_digital_in_bits} : conv_code;
	assign conv_done = cv_q == cv_wait && converter_busy_n && !busy_prev_q;

	// Conversion sequence: apply entry, pulse start, await busy release
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			cv_q         <= cv_idle;
			conv_start_n <= 1'b1;
			mux_entry    <= '0;
			busy_prev_q  <= 1'b1;
		end
		else if (ce)
		begin
			busy_prev_q <= converter_busy_n;
			unique case (cv_q)
				cv_idle:
					if (req_q)
					begin
						mux_entry    <= queue_mem[rd_ptr_q];
						conv_start_n <= 1'b0;
						cv_q         <= cv_start;
					end
				cv_start:
				begin
					conv_start_n <= 1'b1;
					cv_q         <= cv_wait;
				end
				cv_wait:
					if (conv_done)
						cv_q <= cv_idle;
				default:
					cv_q <= cv_idle;
			endcase
		end
	end

	// Sample register, FIFO push and data-available flag
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			sample_q  <= 16'h0000;
			fifo_data <= 16'h0000;
			fifo_push <= 1'b0;
			avail_q   <= 1'b0;
		end
		else if (ce)
		begin
			fifo_push <= conv_done;
			if (conv_done)
			begin
				sample_q  <= word_d;
				fifo_data <= word_d;
			end
			avail_q <= conv_done || (avail_q && !(rd_take && adcsq_hit(s_axi_araddr, adcsq_pkg::OFS_SAMPLE)));
		end
	end

	default clocking adcsq_cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	sequence s_conv_pulse;
		!conv_start_n ##1 conv_start_n;
	endsequence

	property p_capture;
		ce && conv_done |=> sample_q == $past(word_d) && fifo_push;
	endproperty
	a_capture: assert property (p_capture) else $error("Result not captured");

	property p_push_match;
		fifo_push |-> fifo_data == sample_q;
	endproperty
	a_push_match: assert property (p_push_match) else $error("FIFO word differs from sample");

	property p_sdi_nibble;
		ce && conv_done && sdi_fmt_q |=> sample_q[3:0] == $past(sync_digital_in_bits);
	endproperty
	a_sdi_nibble: assert property (p_sdi_nibble) else $error("Digital bits misplaced");

	property p_busy_edge;
		ce && cv_q == cv_wait && !converter_busy_n |=> !fifo_push;
	endproperty
	a_busy_edge: assert property (p_busy_edge) else $error("Capture without busy release");

	property p_sw_one;
		ce && sw_start && cv_q == cv_idle && !req_q ##1 ce |=> s_conv_pulse;
	endproperty
	a_sw_one: assert property (p_sw_one) else $error("Software start gave no single pulse");

	property p_wrap;
		ce && cv_q == cv_idle && req_q && !q_clr && {1'b0, rd_ptr_q} + 10'h001 >= qlen_q |=> rd_ptr_q == 9'h000;
	endproperty
	a_wrap: assert property (p_wrap) else $error("Queue did not wrap");

	property p_qlen;
		qlen_q <= 10'h200;
	endproperty
	a_qlen: assert property (p_qlen) else $error("Queue overfilled");

	property p_hold;
		ce && scan_start && hold_en_q |=> simul_hold_out;
	endproperty
	a_hold: assert property (p_hold) else $error("Hold not raised at scan start");

	property p_irq;
		ce ##1 ce |-> irq == $past(|(stat_q & mask_q));
	endproperty
	a_irq: assert property (p_irq) else $error("Interrupt output wrong");

	property p_issue_bound;
		issue_left_q < nch_q || issue_left_q == '0;
	endproperty
	a_issue_bound: assert property (p_issue_bound) else $error("Too many conversions in scan");

endmodule : adcsq_top

// ==== common/adcsq_pkg.sv ====
// Behaviour
// - Pack each conversion result into one 16-bit word
// - Take digital bits on rising converter busy edge
// - Digital bits fill low nibble, code above
// - Plain variant delivers 16-bit two's complement code
// - One conversion per software start; software polls
// - Entries convert in written order, own settings
// - Queue kept and reused from first entry
// - Queue holds up to 512 entries
// - 24-bit scan interval in base cycles
// - 16-bit sample interval in base cycles
// - 24-bit post-scan count of scans taken
// - 9-bit count of conversions per scan
// - Scan conversions paced only by base counters
// - Software selects internal or external clock base
// - Drive hold output across each scan
// - Push every result into the data FIFO
package adcsq_pkg;

	// System and internal base rates
	localparam int unsigned SYS_CLK_MHZ = 50;
	localparam int unsigned TB_INT_MHZ  = 40;
	localparam logic [6:0]  TB_STEP     = 7'(TB_INT_MHZ);
	localparam logic [6:0]  TB_MOD      = 7'(SYS_CLK_MHZ);

	// Widths and depths
	localparam int unsigned QUEUE_DEPTH = 512;
	localparam int unsigned SI_W        = 24;
	localparam int unsigned SI2_W       = 16;
	localparam int unsigned PSC_W       = 24;
	localparam int unsigned NCH_W       = 9;
	localparam int unsigned IRQ_W       = 3;

	// Register byte offsets
	localparam logic [7:0] OFS_CTRL   = 8'h00;
	localparam logic [7:0] OFS_STATUS = 8'h04;
	localparam logic [7:0] OFS_SI     = 8'h08;
	localparam logic [7:0] OFS_SI2    = 8'h0C;
	localparam logic [7:0] OFS_PSC    = 8'h10;
	localparam logic [7:0] OFS_NCH    = 8'h14;
	localparam logic [7:0] OFS_QUEUE  = 8'h18;
	localparam logic [7:0] OFS_SAMPLE = 8'h1C;
	localparam logic [7:0] OFS_ISTAT  = 8'h20;
	localparam logic [7:0] OFS_IMASK  = 8'h24;

	// Control bit positions
	localparam int unsigned CTRL_RUN    = 0;
	localparam int unsigned CTRL_SWSTRT = 1;
	localparam int unsigned CTRL_EXTTB  = 2;
	localparam int unsigned CTRL_SDIFMT = 3;
	localparam int unsigned CTRL_HOLDEN = 4;
	localparam int unsigned CTRL_QCLR   = 5;

	// Status field positions
	localparam int unsigned ST_AVAIL = 0;
	localparam int unsigned ST_RUN   = 1;
	localparam int unsigned ST_BUSY  = 2;
	localparam int unsigned ST_QLEN  = 8;

	// Interrupt bit positions
	localparam int unsigned IRQ_CONV = 0;
	localparam int unsigned IRQ_SCAN = 1;
	localparam int unsigned IRQ_ACQ  = 2;

	// Reset values
	localparam logic [SI_W-1:0]  SI_RST  = 24'h00_0280;
	localparam logic [SI2_W-1:0] SI2_RST = 16'h00A0;
	localparam logic [PSC_W-1:0] PSC_RST = 24'h00_0000;
	localparam logic [NCH_W-1:0] NCH_RST = 9'h001;

	// Bus answers
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [1:0] {
		grounded_single_ended = 2'h0,
		floating_single_ended = 2'h1,
		differential_input    = 2'h2
	} adcsq_cfg_e;

	// One channel queue entry, also the front-end setting
	typedef struct packed {
		logic [5:0] channel;
		logic [1:0] gain;
		logic       unipolar;
		adcsq_cfg_e in_cfg;
	} adcsq_entry_s;

	localparam int unsigned ENTRY_W = $bits(adcsq_entry_s);

endpackage : adcsq_pkg

// ==== src/adcsq_counter.sv ====
`timescale 1ns/1ns
// Reloading down counter on base ticks
module adcsq_counter #(
	parameter int unsigned W = 16
) (
	input  wire logic         aclk,
	input  wire logic         aresetn,
	input  wire logic         ce,
	input  wire logic         load,
	input  wire logic         tick,
	input  wire logic [W-1:0] period,
	output logic              fire
);

	logic [W-1:0] cnt_q;

	// Fires once every period ticks
	assign fire = tick && !load && (cnt_q <= W'(1));

	// Count down, reload on fire
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			cnt_q <= '0;
		else if (ce)
		begin
			if (load)
				cnt_q <= period;
			else if (tick)
				cnt_q <= fire ? period : cnt_q - W'(1);
		end
	end

	property p_count_step;
		@(posedge aclk) disable iff (!aresetn)
		ce && tick && !load && cnt_q > W'(1) |=> cnt_q == $past(cnt_q) - W'(1);
	endproperty
	a_count_step: assert property (p_count_step) else $error("Pacing counter skipped a step");

endmodule : adcsq_counter

// ==== tb/adcsq_conv_model.sv ====
`timescale 1ns/1ns
// Converter with a single held analog level input, prompt or slow
module adcsq_conv_model (
	input  wire logic        aclk,
	input  wire logic        conv_start_n,
	input  wire logic        slow,
	input  wire logic [15:0] level,
	output logic             busy_n,
	output logic [15:0]      conv_code
);
	logic [15:0] held_q;
	logic [3:0]  left_q;

	// Idle state before any start
	initial
	begin
		busy_n = 1'b1;
		conv_code = 16'h0000;
		left_q = 4'h0;
	end

	// Analog value taken at start, result valid only as busy rises
	always @(posedge aclk)
	begin
		if (!conv_start_n)
		begin
			held_q <= level;
			busy_n <= 1'b0;
			left_q <= slow ? 4'hC : 4'h2;
			conv_code <= ~conv_code;
		end
		else if (left_q == 4'h1)
		begin
			busy_n <= 1'b1;
			conv_code <= held_q;
			left_q <= 4'h0;
		end
		else
		begin
			left_q <= (left_q == 4'h0) ? 4'h0 : left_q - 4'h1;
			conv_code <= ~conv_code;
		end
	end
endmodule : adcsq_conv_model

// ==== tb/tb_top.sv ====
`timescale 1ns/1ns
module tb_top;
	localparam logic [7:0]  CNT_OFS [4] = '{8'h08, 8'h0C, 8'h10, 8'h14};
	localparam logic [31:0] CNT_RST [4] = '{32'h0000_0280, 32'h0000_00A0, 32'h0000_0000, 32'h0000_0001};
	localparam logic [31:0] CNT_MAX [4] = '{32'h00FF_FFFF, 32'h0000_FFFF, 32'h00FF_FFFF, 32'h0000_01FF};
	localparam logic [15:0] CORNER [4]  = '{16'h7FFF, 16'h0000, 16'hFFFF, 16'h8000};
	logic        aclk, aresetn, ce, awv, awr, wv, wr, bv, brdy, arv, arr, rv, rrdy;
	logic        ext, slow, csn, hold, push, irq, busy_n;
	logic [1:0]  bresp, rresp;
	logic [7:0]  awa, ara;
	logic [31:0] wd, rdat, seed;
	logic [15:0] level, ccode, fdat;
	logic [3:0]  sdi;
	logic [2:0]  ediv;
	int          miscompares, compares, cyc;
	int          st[$];
	logic        hl[$];
	logic [15:0] pu[$];
	adcsq_pkg::adcsq_entry_s me, ent[$], ql[4];

	adcsq_top dut (.aclk(aclk), .aresetn(aresetn), .ce(ce), .s_axi_awaddr(awa), .s_axi_awvalid(awv),
		.s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hF), .s_axi_wvalid(wv), .s_axi_wready(wr),
		.s_axi_bresp(bresp), .s_axi_bvalid(bv), .s_axi_bready(brdy), .s_axi_araddr(ara), .s_axi_arvalid(arv),
		.s_axi_arready(arr), .s_axi_rdata(rdat), .s_axi_rresp(rresp), .s_axi_rvalid(rv), .s_axi_rready(rrdy),
		.ext_acq_clock_in(ext), .converter_busy_n(busy_n), .conv_code(ccode), .sync_digital_in_bits(sdi),
		.conv_start_n(csn), .mux_entry(me), .simul_hold_out(hold), .fifo_push(push), .fifo_data(fdat), .irq(irq));
	adcsq_conv_model conv (.aclk(aclk), .conv_start_n(csn), .slow(slow), .level(level), .busy_n(busy_n),
		.conv_code(ccode));

	// Clock at 50 MHz
	initial
	begin
		aclk = 1'b0;
		forever #10 aclk = ~aclk;
	end

	// External base at aclk/8; log of starts and results
	always @(posedge aclk)
	begin
		ediv <= ediv + 3'h1;
		ext <= ediv[2];
		cyc <= cyc + 1;
		if (aresetn && !csn)
		begin
			st.push_back(cyc);
			ent.push_back(me);
			hl.push_back(hold);
		end
		if (push)
			pu.push_back(fdat);
	end

	// Watchdog
	initial
	begin
		repeat (30000) @(posedge aclk);
		miscompares++;
		complete_run();
	end

	function automatic logic [31:0] xs();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction : xs

	// Expected sample word
	function automatic logic [15:0] exp_word(input logic [15:0] c, input logic [3:0] s, input logic f);
		return f ? {c[15:4], s} : c;
	endfunction : exp_word

	// Gap in cycles versus base ticks of num/den cycles
	function automatic logic gap_ok(input int d, input int t, input int num, input int den);
		return (d * den - t * num) <= den + 1 && (t * num - d * den) <= den + 1;
	endfunction : gap_ok

	task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp)
		begin
			miscompares++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk_word

	task automatic chk_flag(input logic got, input logic exp);
		chk_word({31'h0, got}, {31'h0, exp});
	endtask : chk_flag

	task automatic complete_run();
		$display("compares=%0d miscompares=%0d", compares, miscompares);
		if (miscompares == 0 && compares > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : complete_run

	// Bus write, address and data offered together
	task automatic wr_reg(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		awa <= a;
		wd <= d;
		awv <= 1'b1;
		wv <= 1'b1;
		brdy <= 1'b1;
		do
		begin
			@(posedge aclk);
			if (awr)
				awv <= 1'b0;
			if (wr)
				wv <= 1'b0;
		end while (!bv);
		r = bresp;
		brdy <= 1'b0;
		@(posedge aclk);
	endtask : wr_reg

	task automatic rd_reg(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		ara <= a;
		arv <= 1'b1;
		rrdy <= 1'b1;
		do
		begin
			@(posedge aclk);
			if (arr)
				arv <= 1'b0;
		end while (!rv);
		d = rdat;
		r = rresp;
		rrdy <= 1'b0;
		@(posedge aclk);
	endtask : rd_reg

	// Clear the queue and append random entries, input modes in rotation
	task automatic load_queue(input int cnt);
		logic [1:0] r;
		wr_reg(8'h00, 32'h0000_0020, r);
		for (int j = 0; j < cnt; j++)
		begin
			ql[j] = 11'(xs());
			ql[j].in_cfg = adcsq_pkg::adcsq_cfg_e'(2'(j % 3));
			wr_reg(8'h18, {21'h0, ql[j]}, r);
		end
	endtask : load_queue

	// Paced scan run, then order, spacing, hold and count checks
	task automatic scan_run(input logic [31:0] ctl, input int nch, si2, si, num, den, scans);
		logic [31:0] d;
		logic [1:0]  r;
		int          n;
		load_queue(nch);
		wr_reg(8'h0C, 32'(si2), r);
		wr_reg(8'h14, 32'(nch), r);
		wr_reg(8'h08, 32'(si), r);
		wr_reg(8'h10, 32'(scans), r);
		level <= 16'(xs());
		n = st.size();
		wr_reg(8'h00, ctl, r);
		do
			rd_reg(8'h04, d, r);
		while (d[1]);
		repeat (2 * si * num / den) @(posedge aclk);
		chk_word(32'(st.size() - n), 32'(nch * scans));
		for (int j = n; j < st.size(); j++)
		begin
			chk_word(32'(ent[j]), 32'(ql[(j - n) % nch]));
			chk_flag(hl[j], ctl[4]);
			if ((j - n) % nch != 0)
				chk_flag(gap_ok(st[j] - st[j - 1], si2, num, den), 1'b1);
			else if (j != n)
				chk_flag(gap_ok(st[j] - st[j - nch], si, num, den), 1'b1);
		end
		chk_word(32'(pu[pu.size() - 1]), 32'(level));
		chk_flag(irq, 1'b1);
		wr_reg(8'h20, 32'h0000_0007, r);
		repeat (2) @(posedge aclk);
		chk_flag(irq, 1'b0);
	endtask : scan_run

	initial
	begin
		logic [31:0] d;
		logic [1:0]  r;
		logic        f;
		int          n, k;
		seed = 32'h0000_0012;
		aresetn = 1'b0;
		ce = 1'b1;
		{awv, wv, brdy, arv, rrdy, slow, ext} = 7'h00;
		{awa, ara, wd, level, sdi, ediv} = '0;
		cyc = 0;
		repeat (16) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		// Counter registers: reset value, then width
		for (int i = 0; i < 4; i++)
		begin
			rd_reg(CNT_OFS[i], d, r);
			chk_word(d, CNT_RST[i]);
			wr_reg(CNT_OFS[i], 32'hFFFF_FFFF, r);
			rd_reg(CNT_OFS[i], d, r);
			chk_word(d, CNT_MAX[i]);
		end
		wr_reg(8'h28, 32'h0000_0001, r);
		chk_word(32'(r), 32'(adcsq_pkg::RESP_SLVERR));
		rd_reg(8'h28, d, r);
		chk_word({d[31:2], r}, {30'h0, adcsq_pkg::RESP_SLVERR});
		// Software-polled conversions, corner codes then random
		load_queue(4);
		for (int i = 0; i < 10; i++)
		begin
			f = (i < 8) ? i[2] : 1'(xs());
			n = st.size();
			k = pu.size();
			slow <= i[0];
			level <= (i < 8) ? CORNER[i % 4] : 16'(xs());
			sdi <= 4'(xs());
			@(posedge aclk);
			wr_reg(8'h00, {28'h0, f, 3'b010}, r);
			if (i[0])
				sdi <= 4'(xs());
			while (pu.size() == k) @(posedge aclk);
			chk_word(32'(st.size() - n), 32'h0000_0001);
			chk_word(32'(ent[n]), 32'(ql[i % 4]));
			chk_word(32'(pu[k]), 32'(exp_word(level, sdi, f)));
			rd_reg(8'h04, d, r);
			chk_flag(d[0], 1'b1);
			rd_reg(8'h1C, d, r);
			chk_word(d, 32'(exp_word(level, sdi, f)));
			rd_reg(8'h04, d, r);
			chk_flag(d[0], 1'b0);
		end
		// Conversion event masked, unmasked, then cleared
		chk_flag(irq, 1'b0);
		wr_reg(8'h24, 32'h0000_0001, r);
		repeat (2) @(posedge aclk);
		chk_flag(irq, 1'b1);
		wr_reg(8'h20, 32'h0000_0001, r);
		repeat (2) @(posedge aclk);
		chk_flag(irq, 1'b0);
		// Scans: internal base with hold, then external base
		wr_reg(8'h24, 32'h0000_0004, r);
		slow <= 1'b1;
		scan_run(32'h0000_0011, 3, 14, 42, 5, 4, 2);
		scan_run(32'h0000_0005, 2, 4, 12, 8, 1, 2);
		complete_run();
	end
endmodule : tb_top
